// file: rcs_pkg.sv
// Summary of operation
// - Debounce flags: bit 3 selects 40/200 ns
// - Flag when sense falls below threshold
// - Codes 010..111 map -10..-27 mV
// - Two flag settings registers, consecutive addresses
// - Slew code doubles rate from 1.5625 mV/ms
// - Bit 0 enables slew limited adjustment
// - Set flag triggers its selected disable action
package rcs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] REV_A_OFS = 16'hFE84;
    localparam logic [15:0] REV_B_OFS = 16'hFE85;
    localparam logic [15:0] SLEW_A_OFS = 16'hFE86;
    localparam logic [15:0] SLEW_B_OFS = 16'hFE87;
    localparam logic [7:0] REV_RESET = 8'h00;
    localparam logic [7:0] SLEW_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rsvd;
        logic long_deb;
        logic [2:0] thr;
    } rcs_flag_cfg_s;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [2:0] rate;
        logic en;
    } rcs_slew_cfg_s;

    // Flag action select, as driven on the reverse_action input of each flag
    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_DIS_A,
        ACT_DIS_B,
        ACT_DIS_ALL
    } rcs_action_e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int DEB_SHORT_NS = 40;
    localparam int DEB_LONG_NS = 200;
    localparam logic [4:0] DEB_SHORT_CYC =
        5'((DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] DEB_LONG_CYC =
        5'((DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // One output LSB every 250 us at code 000 (4 LSB/ms)
    localparam int SLEW_STEP_NS = 250000;
    localparam int SLEW_BASE_CYC = SLEW_STEP_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Trip levels, sense units of 0.1 mV
    // ------------------------------------------------------------
    localparam logic signed [15:0] THR_010 = -16'sd100;
    localparam logic signed [15:0] THR_011 = -16'sd130;
    localparam logic signed [15:0] THR_100 = -16'sd170;
    localparam logic signed [15:0] THR_101 = -16'sd200;
    localparam logic signed [15:0] THR_110 = -16'sd240;
    localparam logic signed [15:0] THR_111 = -16'sd270;

endpackage

// file: rcs_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module rcs_top import rcs_pkg::*; #(
    parameter int SLEW_BASE_CYCLES = SLEW_BASE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Secondary current sense, flag A at index 0
    input wire logic signed [1:0][15:0] secondary_current_sense,
    input wire logic [1:0][1:0] reverse_action,
    output logic [1:0] reverse_flag,
    output logic disable_pwm_a,
    output logic disable_pwm_b,
    output logic disable_pwm_c,
    // Output voltage setting, channel A at index 0
    input wire logic [1:0][15:0] vout_target,
    output logic [1:0][15:0] vout_ramp
);

    localparam logic [14:0] SLEW_BASE = 15'(SLEW_BASE_CYCLES);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Reserved bits are stored as written; software keeps them zero
    logic [3:0][7:0] regs;
    logic [3:0][7:0] next_regs;
    logic [7:0] next_rd_data;

    // Write decode and one-cycle read data
    // Unmapped writes fall through and leave every register alone
    always_comb begin
        next_regs = regs;
        next_rd_data = 8'h00;
        if (wr_en) begin
            unique case (addr)
                REV_A_OFS: next_regs[0] = wr_data;
                REV_B_OFS: next_regs[1] = wr_data;
                SLEW_A_OFS: next_regs[2] = wr_data;
                SLEW_B_OFS: next_regs[3] = wr_data;
                default: next_regs = regs;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                REV_A_OFS: next_rd_data = regs[0];
                REV_B_OFS: next_rd_data = regs[1];
                SLEW_A_OFS: next_rd_data = regs[2];
                SLEW_B_OFS: next_rd_data = regs[3];
                default: next_rd_data = 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // Reset leaves both flags unarmed and slew limiting off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regs <= {SLEW_RESET, SLEW_RESET, REV_RESET, REV_RESET};
            rd_data <= 8'h00;
        end else begin
            regs <= next_regs;
            rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Reverse current flags and output voltage ramps
    // ------------------------------------------------------------
    // One flag and one ramp per channel, A at index 0, B at index 1
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            rcs_flag_cfg_s fcfg;
            rcs_slew_cfg_s scfg;
            logic signed [15:0] level;
            logic level_ok;
            logic raw_trip;
            logic [4:0] deb_lim;
            logic [4:0] deb_cnt;
            logic [4:0] next_deb_cnt;
            logic next_flag;
            logic [14:0] period;
            logic [14:0] tmr;
            logic [14:0] next_tmr;
            logic [15:0] next_ramp;

            assign fcfg = rcs_flag_cfg_s'(regs[i]);
            assign scfg = rcs_slew_cfg_s'(regs[i+2]);

            // Trip level lookup; reserved codes never trip
            // Levels are in sense units of 0.1 mV; equal does not trip
            always_comb begin
                level = THR_010;
                level_ok = 1'b1;
                unique case (fcfg.thr)
                    3'h2: level = THR_010;
                    3'h3: level = THR_011;
                    3'h4: level = THR_100;
                    3'h5: level = THR_101;
                    3'h6: level = THR_110;
                    3'h7: level = THR_111;
                    default: level_ok = 1'b0;
                endcase
            end

            // compare below threshold
            // An element select of the packed port drops its sign
            assign raw_trip = level_ok &&
                ($signed(secondary_current_sense[i]) < level);
            assign deb_lim = fcfg.long_deb ? DEB_LONG_CYC : DEB_SHORT_CYC;

            // Flag moves only after the new state held deb_lim cycles
            // A bounce back restarts the count, so a glitch shorter
            // than the window never moves the flag
            always_comb begin
                next_flag = reverse_flag[i];
                next_deb_cnt = 5'h00;
                if (raw_trip != reverse_flag[i]) begin
                    if (deb_cnt + 5'h01 >= deb_lim) begin
                        next_flag = raw_trip;
                    end else begin
                        next_deb_cnt = deb_cnt + 5'h01;
                    end
                end
            end

            // Step period halves with each higher rate code
            // With a base below 128 the top codes stop doubling the rate
            assign period = SLEW_BASE >> scfg.rate;

            // One LSB step toward target per period
            // Timer rests at zero on target, so a new target waits one
            // full period before the first step
            always_comb begin
                next_ramp = vout_ramp[i];
                next_tmr = 15'h0000;
                if (!scfg.en) begin
                    next_ramp = vout_target[i];
                end else if (vout_ramp[i] != vout_target[i]) begin
                    if (tmr + 15'h0001 >= period) begin
                        if (vout_ramp[i] < vout_target[i]) begin
                            next_ramp = vout_ramp[i] + 16'h0001;
                        end else begin
                            next_ramp = vout_ramp[i] - 16'h0001;
                        end
                    end else begin
                        next_tmr = tmr + 15'h0001;
                    end
                end
            end

            // Channel state; flag and ramp drive the outputs directly
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    reverse_flag[i] <= 1'b0;
                    deb_cnt <= 5'h00;
                    vout_ramp[i] <= 16'h0000;
                    tmr <= 15'h0000;
                end else begin
                    reverse_flag[i] <= next_flag;
                    deb_cnt <= next_deb_cnt;
                    vout_ramp[i] <= next_ramp;
                    tmr <= next_tmr;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Flag actions
    // ------------------------------------------------------------
    logic next_dis_a;
    logic next_dis_b;
    logic next_dis_c;

    // Merge the disable requests of both flags
    // Both flags may ask at once, so requests are OR-ed together
    always_comb begin
        next_dis_a = 1'b0;
        next_dis_b = 1'b0;
        next_dis_c = 1'b0;
        for (int k = 0; k < 2; k++) begin
            if (reverse_flag[k]) begin
                unique case (rcs_action_e'(reverse_action[k]))
                    ACT_NONE: begin
                        // Flag is reported but nothing is disabled
                    end
                    ACT_DIS_A: next_dis_a = 1'b1;
                    ACT_DIS_B: next_dis_b = 1'b1;
                    ACT_DIS_ALL: begin
                        next_dis_a = 1'b1;
                        next_dis_b = 1'b1;
                        next_dis_c = 1'b1;
                    end
                endcase
            end
        end
    end

    // Disable requests lag the flag by one edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            disable_pwm_a <= 1'b0;
            disable_pwm_b <= 1'b0;
            disable_pwm_c <= 1'b0;
        end else begin
            disable_pwm_a <= next_dis_a;
            disable_pwm_b <= next_dis_b;
            disable_pwm_c <= next_dis_c;
        end
    end

endmodule // rcs_top

// file: rcs_top_chk.sv
`timescale 1ns/1ps
module rcs_top_chk import rcs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    // Flags
    input wire logic signed [1:0][15:0] secondary_current_sense,
    input wire logic [1:0][1:0] reverse_action,
    input wire logic [1:0] reverse_flag,
    input wire logic disable_pwm_a,
    input wire logic disable_pwm_b,
    input wire logic disable_pwm_c,
    // Output voltage
    input wire logic [1:0][15:0] vout_target,
    input wire logic [1:0][15:0] vout_ramp
);
    logic en_a;
    logic next_en_a;
    logic [1:0] low;
    logic [2:0] want;
    // Raw trip state below the shallowest level, and wanted disables
    assign low[0] = $signed(secondary_current_sense[0]) < THR_010;
    assign low[1] = $signed(secondary_current_sense[1]) < THR_010;
    assign want[0] = |(reverse_flag & {reverse_action[1][0],
        reverse_action[0][0]});
    assign want[1] = |(reverse_flag & {reverse_action[1][1],
        reverse_action[0][1]});
    assign want[2] = |(reverse_flag & {&reverse_action[1],
        &reverse_action[0]});
    // Shadow of the channel A slew enable
    always_comb begin
        next_en_a = en_a;
        if (wr_en && addr == SLEW_A_OFS) next_en_a = wr_data[0];
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) en_a <= 1'b0;
        else en_a <= next_en_a;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_rd_idle; !$past(rd_en) |-> rd_data == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its slot");
    property p_rd_map;
        rd_en && (addr < REV_A_OFS || addr > SLEW_B_OFS) |=> rd_data == 8'h00;
    endproperty
    a_rd_map: assert property (p_rd_map)
        else $error("unmapped read not zero");
    property p_trip_a; $rose(reverse_flag[0]) |-> low[0] && $past(low[0], 4);
    endproperty
    a_trip_a: assert property (p_trip_a)
        else $error("flag A rose without debounced trip");
    property p_trip_b; $rose(reverse_flag[1]) |-> low[1] && $past(low[1], 4);
    endproperty
    a_trip_b: assert property (p_trip_b)
        else $error("flag B rose without debounced trip");
    property p_dis_a; disable_pwm_a == $past(want[0]); endproperty
    a_dis_a: assert property (p_dis_a)
        else $error("channel A disable wrong");
    property p_dis_b; disable_pwm_b == $past(want[1]); endproperty
    a_dis_b: assert property (p_dis_b)
        else $error("channel B disable wrong");
    property p_dis_c; disable_pwm_c == $past(want[2]); endproperty
    a_dis_c: assert property (p_dis_c)
        else $error("all outputs disable wrong");
    property p_ramp_step;
        en_a && $past(en_a) && $changed(vout_ramp[0]) |->
            vout_ramp[0] - $past(vout_ramp[0]) inside {16'h0001, 16'hFFFF};
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp moved more than one step");
    property p_ramp_copy;
        !en_a && !$past(en_a) && $past(reset_n) |->
            vout_ramp[0] == $past(vout_target[0]);
    endproperty
    a_ramp_copy: assert property (p_ramp_copy)
        else $error("ramp not following target");
endmodule // rcs_top_chk
bind rcs_top rcs_top_chk u_chk (.clk, .reset_n, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .secondary_current_sense, .reverse_action,
    .reverse_flag, .disable_pwm_a, .disable_pwm_b, .disable_pwm_c,
    .vout_target, .vout_ramp);

// file: tb.sv
`timescale 1ns/1ps
module tb import rcs_pkg::*;;
    logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, dis_a, dis_b, dis_c;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic signed [1:0][15:0] sense = '0;
    logic [1:0][1:0] act = '0;
    logic [1:0] flag;
    logic [1:0][15:0] tgt = '0, ramp;
    int failures = 0, compares = 0;
    always #4 clk = ~clk;
    rcs_top #(.SLEW_BASE_CYCLES(128)) uut (.clk, .reset_n, .addr, .wr_data,
        .wr_en, .rd_en, .rd_data, .secondary_current_sense(sense),
        .reverse_action(act), .reverse_flag(flag), .disable_pwm_a(dis_a),
        .disable_pwm_b(dis_b), .disable_pwm_c(dis_c), .vout_target(tgt),
        .vout_ramp(ramp));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wr_data, wr_en} <= {a, d, 1'b1};
        @(posedge clk) wr_en <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk) {addr, rd_en} <= {a, 1'b1};
        @(posedge clk) rd_en <= 1'b0;
        #1 chk({8'h00, rd_data}, {8'h00, exp});
    endtask
    task t_regs;
        for (int i = 0; i < 4; i++) rd(REV_A_OFS + 16'(i), 8'h00);
        for (int i = 0; i < 4; i++)
            wr(REV_A_OFS + 16'(i), 8'h0A + 8'(i));
        wr(16'hFE88, 8'hFF);
        for (int i = 0; i < 4; i++)
            rd(REV_A_OFS + 16'(i), 8'h0A + 8'(i));
        rd(16'hFE83, 8'h00);
    endtask
    task trip(input int f, input logic [2:0] c, input logic [15:0] v,
        input int n);
        int cnt;
        cnt = 0;
        wr(REV_A_OFS + 16'(f), {4'h0, n == 25, c});
        @(posedge clk) sense[f] <= v;
        while (cnt < 40 && flag[f] !== 1'b1) begin
            @(posedge clk);
            #1 cnt++;
        end
        chk(16'(cnt), 16'(n));
        if (cnt == 40 && n != 40) stop_test;
        @(posedge clk) sense[f] <= 16'h0000;
        repeat (30) @(posedge clk);
        #1 chk(16'(flag[f]), 16'h0000);
    endtask
    task t_flags;
        logic [15:0] lv [8];
        lv = '{16'h8000, 16'h8000, THR_010, THR_011, THR_100, THR_101,
            THR_110, THR_111};
        for (int c = 0; c < 8; c++) begin
            trip(0, 3'(c), lv[c], 40);
            if (c > 1) trip(0, 3'(c), lv[c] - 16'h0001, 5);
        end
        trip(1, 3'd7, THR_111 - 16'h0001, 25);
        // Short glitch must not trip
        @(posedge clk) sense[0] <= -16'sd300;
        repeat (4) @(posedge clk);
        sense[0] <= 16'h0000;
        repeat (10) @(posedge clk);
        #1 chk(16'(flag[0]), 16'h0000);
        @(posedge clk) {sense[0], act[1]} <= {-16'sd300, 2'd3};
        for (int a = 0; a < 4; a++) begin
            repeat (8) @(posedge clk);
            act[0] <= 2'(a);
            repeat (2) @(posedge clk);
            #1 chk({dis_c, dis_b, dis_a}, {a == 3, 2'(a)});
        end
        @(posedge clk) {sense[0], act} <= '0;
    endtask
    task ramp_to(input int ch, input logic [15:0] t, input int n);
        int cnt;
        cnt = 0;
        @(posedge clk) tgt[ch] <= t;
        while (cnt < 300 && ramp[ch] !== t) begin
            @(posedge clk);
            #1 cnt++;
        end
        chk(16'(cnt), 16'(n));
        if (cnt == 300) stop_test;
    endtask
    task t_slew;
        wr(SLEW_A_OFS, 8'h00);
        wr(SLEW_B_OFS, 8'h00);
        @(posedge clk) tgt <= {16'h0456, 16'h0123};
        repeat (2) @(posedge clk);
        #1 chk(ramp[0], 16'h0123);
        chk(ramp[1], 16'h0456);
        for (int c = 0; c < 8; c++) begin
            wr(SLEW_A_OFS, {4'h0, 3'(c), 1'b1});
            ramp_to(0, 16'h0124 + 16'(c), 128 >> c);
        end
        ramp_to(0, 16'h012E, 3);
        ramp_to(0, 16'h012B, 3);
        wr(SLEW_B_OFS, 8'h0F);
        ramp_to(1, 16'h0459, 3);
    endtask
    task t_reset;
        wr(REV_A_OFS, 8'h0B);
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(REV_A_OFS, 8'h00);
        chk(ramp[0], tgt[0]);
        chk(ramp[1], tgt[1]);
        chk(16'(flag), 16'h0000);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_regs;
        t_flags;
        t_slew;
        t_reset;
        stop_test;
    end
endmodule // tb
